// *** hdl/mudc_top.sv ***
// Modulo / up-down counter with two threshold outputs and AHB-Lite registers
//
// Register access over AHB-Lite and the register offsets were decided locally.
module mudc_top #(
  parameter int PULSE_CYC = mudc_pkg::PULSE_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Counting pins
  input wire logic cnt_in_a,
  input wire logic cnt_in_b,
  input wire logic restart_in,
  // Discrete outputs
  output logic out1,
  output logic out2
);
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // In-range test, both bounds inclusive
  function automatic logic in_win(input logic [15:0] v,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_win = (v >= lo) && (v <= hi);
  endfunction

  // Two-flop synchronisers for pins
  logic [2:0] pin_m_q, pin_s_q, pin_p_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_m_q <= 3'h0;
      pin_s_q <= 3'h0;
      pin_p_q <= 3'h0;
    end else begin
      pin_m_q <= {restart_in, cnt_in_b, cnt_in_a};
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end
  end
  // Rising edges; 200 MHz sampling easily covers 40 kHz inputs
  logic a_rise, b_rise, r_rise, a_lvl, b_lvl;
  assign a_lvl = pin_s_q[0];
  assign b_lvl = pin_s_q[1];
  assign a_rise = pin_s_q[0] & ~pin_p_q[0];
  assign b_rise = pin_s_q[1] & ~pin_p_q[1];
  assign r_rise = pin_s_q[2] & ~pin_p_q[2];

  // Registers
  logic [31:0] ctrl_q;
  logic [15:0] low_q, high_q, preset_q;
  logic [15:0] count_q, capt_q;
  logic running_q;
  logic [1:0] func;
  logic [1:0] udm;
  assign func = ctrl_q[mudc_pkg::CTRL_FUNC_LSB +: 2];
  assign udm = ctrl_q[mudc_pkg::CTRL_UDM_LSB +: 2];

  // Bus fsm: address phase registered, data phase one cycle later
  mudc_pkg::mudc_bus_e st_q;
  logic ap_wr_q, ap_rd_q;
  logic [7:0] ap_addr_q;
  logic ap_take;
  assign ap_take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= mudc_pkg::MUDC_IDLE;
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ap_wr_q <= ap_take & hwrite;
      ap_rd_q <= ap_take & ~hwrite;
      if (ap_take) begin
        ap_addr_q <= haddr;
      end
      case (st_q)
        mudc_pkg::MUDC_IDLE: st_q <= ap_take ? mudc_pkg::MUDC_DATA
                                             : mudc_pkg::MUDC_IDLE;
        mudc_pkg::MUDC_DATA: st_q <= ap_take ? mudc_pkg::MUDC_DATA
                                             : mudc_pkg::MUDC_IDLE;
        default: st_q <= mudc_pkg::MUDC_IDLE;
      endcase
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Register writes in the data phase
  logic wr_ctrl, wr_preset;
  assign wr_ctrl = ap_wr_q && ap_addr_q == mudc_pkg::ADDR_CTRL;
  assign wr_preset = ap_wr_q && ap_addr_q == mudc_pkg::ADDR_PRESET;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= mudc_pkg::CTRL_RST;
      low_q <= mudc_pkg::CNT_ZERO;
      high_q <= mudc_pkg::CNT_MAX;
      preset_q <= mudc_pkg::CNT_ZERO;
    end else if (ap_wr_q) begin
      case (ap_addr_q)
        mudc_pkg::ADDR_CTRL: ctrl_q <= hwdata & mudc_pkg::CTRL_MASK;
        mudc_pkg::ADDR_LOW: low_q <= hwdata[15:0];
        mudc_pkg::ADDR_HIGH: high_q <= hwdata[15:0];
        mudc_pkg::ADDR_PRESET: preset_q <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read data: combinational select, registered so it stands at the edge
  // where the master takes it; write-phase data is unaffected.
  logic [31:0] rd_d;
  always_comb begin
    rd_d = ZERO32;
    case (haddr)
      mudc_pkg::ADDR_CTRL: rd_d = ctrl_q;
      mudc_pkg::ADDR_LOW: rd_d = {16'h0000, low_q};
      mudc_pkg::ADDR_HIGH: rd_d = {16'h0000, high_q};
      mudc_pkg::ADDR_PRESET: rd_d = {16'h0000, preset_q};
      mudc_pkg::ADDR_COUNT: rd_d = {16'h0000, count_q};
      mudc_pkg::ADDR_CAPT: rd_d = {16'h0000, capt_q};
      mudc_pkg::ADDR_STAT: rd_d = {29'h0000_0000, out2, out1, running_q};
      default: rd_d = ZERO32;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= ZERO32;
    end else if (ap_take & ~hwrite) begin
      hrdata <= rd_d;
    end
  end

  // Count step decode per function and input scheme
  logic step_up, step_dn, restart;
  logic enc_a_q;
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    restart = 1'b0;
    case (func)
      mudc_pkg::FN_MODULO: begin
        restart = b_rise;
        step_up = a_rise;
      end
      mudc_pkg::FN_DOWN: begin
        restart = b_rise;
        step_dn = a_rise;
      end
      mudc_pkg::FN_UPDOWN: begin
        restart = r_rise;
        case (udm)
          mudc_pkg::UD_DIR: begin
            step_up = a_rise & ~b_lvl;
            step_dn = a_rise & b_lvl;
          end
          mudc_pkg::UD_ENC: begin
            // x1 decode on A edges, B level gives the phase
            step_up = (a_lvl & ~enc_a_q) & ~b_lvl;
            step_dn = (a_lvl & ~enc_a_q) & b_lvl;
          end
          default: begin
            step_up = a_rise;
            step_dn = b_rise;
          end
        endcase
      end
      default: ;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enc_a_q <= 1'b0;
    end else begin
      enc_a_q <= a_lvl;
    end
  end

  // Counter core
  logic sw_run;
  assign sw_run = ctrl_q[mudc_pkg::CTRL_RUN_BIT];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= mudc_pkg::CNT_ZERO;
      capt_q <= mudc_pkg::CNT_ZERO;
      running_q <= 1'b0;
    end else if (restart && sw_run) begin
      // Restart wins over a control write in the same cycle
      running_q <= 1'b1;
      case (func)
        mudc_pkg::FN_MODULO: begin
          capt_q <= count_q;
          count_q <= mudc_pkg::CNT_ZERO;
        end
        mudc_pkg::FN_DOWN: count_q <= high_q;
        default: count_q <= preset_q;
      endcase
    end else if (wr_ctrl) begin
      running_q <= 1'b0;                     // Mode change stops counting
    end else if (running_q && sw_run) begin
      if (func == mudc_pkg::FN_MODULO && step_up) begin
        // Wrap when pulse count reaches the modulo
        count_q <= (count_q + 16'h0001 >= high_q) ? mudc_pkg::CNT_ZERO
                                                  : count_q + 16'h0001;
      end else if (func == mudc_pkg::FN_DOWN && step_dn) begin
        if (count_q != mudc_pkg::CNT_ZERO) begin
          count_q <= count_q - 16'h0001;
        end
        if (count_q == 16'h0001) begin
          running_q <= 1'b0;
        end
      end else if (func == mudc_pkg::FN_UPDOWN) begin
        if (step_up && !step_dn && count_q != mudc_pkg::CNT_MAX) begin
          count_q <= count_q + 16'h0001;
        end else if (step_dn && !step_up &&
                     count_q != mudc_pkg::CNT_ZERO) begin
          count_q <= count_q - 16'h0001;
        end
      end
    end
    // Otherwise the count holds
  end

  // Downward crossing detection for pulse modes
  logic [15:0] prev_q;
  logic cross_lo, cross_hi;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= mudc_pkg::CNT_ZERO;
    end else begin
      prev_q <= count_q;
    end
  end
  assign cross_lo = (prev_q >= low_q) && (count_q < low_q);
  assign cross_hi = (prev_q >= high_q) && (count_q < high_q);

  // Output mode evaluation, shared by both outputs
  function automatic logic out_lvl(input logic [3:0] m,
                                   input logic [15:0] c,
                                   input logic [15:0] cp,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi,
                                   input logic [1:0] fn,
                                   input logic run,
                                   input logic pls);
    case (m)
      mudc_pkg::OM_BELOW: out_lvl = c < lo;
      mudc_pkg::OM_INSIDE: out_lvl = in_win(c, lo, hi);
      mudc_pkg::OM_ABOVE: out_lvl = c > hi;
      mudc_pkg::OM_PLOW: out_lvl = pls;
      mudc_pkg::OM_PHIGH: out_lvl = pls;
      mudc_pkg::OM_RUN: out_lvl = run && fn == mudc_pkg::FN_DOWN;
      mudc_pkg::OM_CAPT:
        out_lvl = fn == mudc_pkg::FN_MODULO && cp < lo;
      mudc_pkg::OM_MODWIN:
        out_lvl = fn == mudc_pkg::FN_MODULO && in_win(c, lo, hi);
      default: out_lvl = 1'b0;
    endcase
  endfunction

  // Pulse stretchers, one per output
  localparam int PW = $clog2(PULSE_CYC + 1);
  logic [PW-1:0] p1_q, p2_q;
  logic [3:0] m1, m2;
  logic t1, t2;
  assign m1 = ctrl_q[mudc_pkg::CTRL_O1_LSB +: 4];
  assign m2 = ctrl_q[mudc_pkg::CTRL_O2_LSB +: 4];
  assign t1 = (m1 == mudc_pkg::OM_PLOW && cross_lo) ||
              (m1 == mudc_pkg::OM_PHIGH && cross_hi);
  assign t2 = (m2 == mudc_pkg::OM_PLOW && cross_lo) ||
              (m2 == mudc_pkg::OM_PHIGH && cross_hi);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p1_q <= '0;
      p2_q <= '0;
    end else begin
      p1_q <= t1 ? PW'(PULSE_CYC) : (p1_q != '0 ? p1_q - 1'b1 : p1_q);
      p2_q <= t2 ? PW'(PULSE_CYC) : (p2_q != '0 ? p2_q - 1'b1 : p2_q);
    end
  end

  // Registered discrete outputs, modes chosen independently
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out1 <= 1'b0;
      out2 <= 1'b0;
    end else begin
      out1 <= out_lvl(m1, count_q, capt_q, low_q, high_q, func,
                      running_q, t1 || p1_q > PW'(1));
      out2 <= out_lvl(m2, count_q, capt_q, low_q, high_q, func,
                      running_q, t2 || p2_q > PW'(1));
    end
  end

  // Checks
  chk_mod_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    (!wr_ctrl && restart && sw_run && func == mudc_pkg::FN_MODULO) |=>
    (capt_q == $past(count_q) && count_q == mudc_pkg::CNT_ZERO))
    else $error("modulo restart did not capture and clear");
  // Step checks; restart and control writes excluded
  chk_mod_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    (func == mudc_pkg::FN_MODULO && running_q && sw_run && step_up &&
     !restart && !wr_ctrl) |=>
    (count_q < $past(high_q) || count_q == mudc_pkg::CNT_ZERO))
    else $error("modulo count reached modulo value");
  chk_mod_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (func == mudc_pkg::FN_MODULO && running_q && sw_run && step_up &&
     !restart && !wr_ctrl && count_q + 16'h0001 < high_q) |=>
    count_q == $past(count_q) + 16'h0001)
    else $error("modulo count did not step up");
  chk_ud_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (func == mudc_pkg::FN_UPDOWN && udm == mudc_pkg::UD_SPLIT &&
     running_q && sw_run && !restart && !wr_ctrl && a_rise && !b_rise &&
     count_q != mudc_pkg::CNT_MAX) |=>
    count_q == $past(count_q) + 16'h0001)
    else $error("up/down count did not step up");
  chk_ud_preset: assert property (@(posedge hclk) disable iff (!hresetn)
    (!wr_ctrl && restart && sw_run && func == mudc_pkg::FN_UPDOWN) |=>
    count_q == $past(preset_q))
    else $error("preset not loaded on restart");
  chk_ud_sat: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(count_q) == mudc_pkg::CNT_MAX && func == mudc_pkg::FN_UPDOWN &&
     !$past(restart)) |-> count_q != mudc_pkg::CNT_ZERO)
    else $error("up/down count wrapped past maximum");
  chk_down_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    (func == mudc_pkg::FN_DOWN && count_q == mudc_pkg::CNT_ZERO &&
     !restart) |=> count_q == mudc_pkg::CNT_ZERO)
    else $error("down counter left zero without restart");
  chk_hold_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    (!running_q && !restart) |=> $stable(count_q))
    else $error("stopped counter changed");
  chk_below_out: assert property (@(posedge hclk) disable iff (!hresetn)
    (m1 == mudc_pkg::OM_BELOW && $stable(m1)) |=>
    out1 == ($past(count_q) < $past(low_q)))
    else $error("below output wrong");
  chk_window_out: assert property (@(posedge hclk) disable iff (!hresetn)
    (m2 == mudc_pkg::OM_INSIDE && $stable(m2)) |=>
    out2 == ($past(count_q) >= $past(low_q) &&
             $past(count_q) <= $past(high_q)))
    else $error("window output wrong");
  // Output level checks, one cycle behind their inputs
  chk_above_out: assert property (@(posedge hclk) disable iff (!hresetn)
    (m2 == mudc_pkg::OM_ABOVE && $stable(m2)) |=>
    out2 == ($past(count_q) > $past(high_q)))
    else $error("above output wrong");
  chk_run_out: assert property (@(posedge hclk) disable iff (!hresetn)
    (m1 == mudc_pkg::OM_RUN && $stable(m1)) |=>
    out1 == ($past(running_q) && $past(func) == mudc_pkg::FN_DOWN))
    else $error("running output wrong");
  chk_capt_out: assert property (@(posedge hclk) disable iff (!hresetn)
    (m1 == mudc_pkg::OM_CAPT && $stable(m1)) |=>
    out1 == ($past(func) == mudc_pkg::FN_MODULO &&
             $past(capt_q) < $past(low_q)))
    else $error("capture output wrong");
  chk_pulse_len: assert property (@(posedge hclk) disable iff (!hresetn)
    (t2 && m2 == mudc_pkg::OM_PLOW) |=> out2 [*2])
    else $error("low crossing pulse too short");
  chk_high_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    (t1 && m1 == mudc_pkg::OM_PHIGH) |=> out1 [*2])
    else $error("high crossing pulse too short");
endmodule // mudc_top

// *** hdl/mudc_pkg.sv ***
// Package: register map, field layout and modes of the modulo up/down counter
package mudc_pkg;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  // Byte addresses of the registers
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LOW = 8'h04;
  localparam logic [7:0] ADDR_HIGH = 8'h08;
  localparam logic [7:0] ADDR_PRESET = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_CAPT = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  // Control register fields
  localparam int CTRL_FUNC_LSB = 0;  // 2 bits, counting function
  localparam int CTRL_UDM_LSB = 2;   // 2 bits, up/down input scheme
  localparam int CTRL_O1_LSB = 4;    // 4 bits, output 1 mode
  localparam int CTRL_O2_LSB = 8;    // 4 bits, output 2 mode
  localparam int CTRL_RUN_BIT = 12;  // Software stop/go
  localparam logic [31:0] CTRL_RST = 32'h0000_1000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_1FFF;
  // Pulse output width in clock cycles
  localparam int PULSE_CYC = 4;
  // Counting functions
  localparam logic [1:0] FN_MODULO = 2'h0;
  localparam logic [1:0] FN_UPDOWN = 2'h1;
  localparam logic [1:0] FN_DOWN = 2'h2;
  // Up/down input schemes
  localparam logic [1:0] UD_SPLIT = 2'h0;
  localparam logic [1:0] UD_DIR = 2'h1;
  localparam logic [1:0] UD_ENC = 2'h2;
  // Output modes
  localparam logic [3:0] OM_NONE = 4'h0;
  localparam logic [3:0] OM_BELOW = 4'h1;
  localparam logic [3:0] OM_INSIDE = 4'h2;
  localparam logic [3:0] OM_ABOVE = 4'h3;
  localparam logic [3:0] OM_PLOW = 4'h4;
  localparam logic [3:0] OM_PHIGH = 4'h5;
  localparam logic [3:0] OM_RUN = 4'h6;
  localparam logic [3:0] OM_CAPT = 4'h7;
  localparam logic [3:0] OM_MODWIN = 4'h8;
  // Bus fsm states
  typedef enum logic [1:0] {
    MUDC_IDLE = 2'b01,
    MUDC_DATA = 2'b10
  } mudc_bus_e;
endpackage

// *** testbench/mudc_pulse_src.sv ***
// Sensor and encoder model driving the three counting pins
module mudc_pulse_src (
  // Clock
  input wire logic hclk,
  // Counting pins
  output logic cnt_in_a,
  output logic cnt_in_b,
  output logic restart_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins rest low between pulses
  initial begin
    cnt_in_a = 1'b0;
    cnt_in_b = 1'b0;
    restart_in = 1'b0;
  end
  // Pin 0 is a, 1 is b, anything else restart
  task automatic drive(input int pin, input logic v);
    case (pin)
      0: cnt_in_a <= v;
      1: cnt_in_b <= v;
      default: restart_in <= v;
    endcase
  endtask
  // Four cycles high, four low: long enough for the two-flop sync
  task automatic pulse(input int pin, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      drive(pin, 1'b1);
      repeat (4) @(posedge hclk);
      drive(pin, 1'b0);
      repeat (4) @(posedge hclk);
    end
  endtask
  // Level on b, used as direction or quadrature phase
  task automatic level_b(input logic v);
    @(posedge hclk);
    cnt_in_b <= v;
    repeat (4) @(posedge hclk);
  endtask
endmodule // mudc_pulse_src

// *** testbench/test_modulo_updown_counter_outputs.sv ***
// Self-checking bench of the modulo up/down counter
module test_modulo_updown_counter_outputs;
  timeunit 1ns;
  timeprecision 1ps;
  // Short pulse width, so the parameter is seen to reach the outputs
  localparam int PCYC = 3;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, out1, out2, cnt_in_a, cnt_in_b, restart_in;
  int error_cnt = 0;
  int n_tests = 0;
  // 200 MHz clock
  always #2.5 hclk = ~hclk;
  mudc_top #(.PULSE_CYC(PCYC)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cnt_in_a(cnt_in_a),
    .cnt_in_b(cnt_in_b), .restart_in(restart_in), .out1(out1),
    .out2(out2));
  mudc_pulse_src src (.hclk(hclk), .cnt_in_a(cnt_in_a),
    .cnt_in_b(cnt_in_b), .restart_in(restart_in));
  // Verdict and end of run
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // One single AHB-Lite word transfer; waits on hready, never a fixed count
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && t < 50) begin
      @(posedge hclk);
      t++;
    end
    chk("hready", 32'h1, {31'h0, hreadyout});
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && t < 100) begin
      @(posedge hclk);
      t++;
    end
    chk("hready", 32'h1, {31'h0, hreadyout});
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r);
  endtask
  // Outputs are levels registered one cycle behind the count
  task automatic outs(input logic e1, input logic e2);
    chk("out1", {31'h0, e1}, {31'h0, out1});
    chk("out2", {31'h0, e2}, {31'h0, out2});
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] fn,
    input logic [1:0] ud, input logic [3:0] o1, input logic [3:0] o2);
    return {19'h0, 1'b1, o2, o1, ud, fn};
  endfunction
  // Writing the control word stops the counter until a restart pulse
  task automatic setup(input logic [31:0] c, input logic [15:0] lo,
                       input logic [15:0] hi, input logic [15:0] pre);
    wreg(mudc_pkg::ADDR_LOW, {16'h0, lo});
    wreg(mudc_pkg::ADDR_HIGH, {16'h0, hi});
    wreg(mudc_pkg::ADDR_PRESET, {16'h0, pre});
    wreg(mudc_pkg::ADDR_CTRL, c);
  endtask
  task automatic t_reset();
    rchk("ctrl", mudc_pkg::ADDR_CTRL, mudc_pkg::CTRL_RST);
    rchk("high", mudc_pkg::ADDR_HIGH, 32'h0000_FFFF);
    rchk("low", mudc_pkg::ADDR_LOW, 32'h0);
    rchk("preset", mudc_pkg::ADDR_PRESET, 32'h0);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'h0);
    rchk("capt", mudc_pkg::ADDR_CAPT, 32'h0);
    outs(1'b0, 1'b0);
    wreg(8'h1C, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h1C, 32'h0);
  endtask
  task automatic t_modulo();
    setup(cfg(mudc_pkg::FN_MODULO, mudc_pkg::UD_SPLIT, mudc_pkg::OM_CAPT,
      mudc_pkg::OM_MODWIN), 16'h0004, 16'h0005, 16'h0000);
    src.pulse(0, 2);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'h0);
    src.pulse(1, 1);
    src.pulse(0, 3);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'h3);
    src.pulse(1, 1);
    rchk("capt", mudc_pkg::ADDR_CAPT, 32'h3);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'h0);
    outs(1'b1, 1'b0);
    src.pulse(0, 4);
    outs(1'b1, 1'b1);
    src.pulse(0, 1);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'h0);
  endtask
  task automatic t_updown();
    setup(cfg(mudc_pkg::FN_UPDOWN, mudc_pkg::UD_SPLIT, mudc_pkg::OM_BELOW,
      mudc_pkg::OM_ABOVE), 16'h0003, 16'h0004, 16'h0002);
    src.pulse(2, 1);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'h2);
    outs(1'b1, 1'b0);
    src.pulse(1, 3);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'h0);
    src.pulse(0, 5);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'h5);
    outs(1'b0, 1'b1);
  endtask
  task automatic t_dir_enc();
    setup(cfg(mudc_pkg::FN_UPDOWN, mudc_pkg::UD_DIR, mudc_pkg::OM_INSIDE,
      mudc_pkg::OM_NONE), 16'h0003, 16'h0004, 16'h0004);
    src.pulse(2, 1);
    outs(1'b1, 1'b0);
    src.level_b(1'b1);
    src.pulse(0, 1);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'h3);
    outs(1'b1, 1'b0);
    src.pulse(0, 1);
    outs(1'b0, 1'b0);
    src.level_b(1'b0);
    setup(cfg(mudc_pkg::FN_UPDOWN, mudc_pkg::UD_ENC, mudc_pkg::OM_NONE,
      mudc_pkg::OM_NONE), 16'h0003, 16'h0004, 16'hFFFF);
    src.pulse(2, 1);
    src.pulse(0, 1);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'hFFFF);
    src.level_b(1'b1);
    src.pulse(0, 1);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'hFFFE);
    src.level_b(1'b0);
  endtask
  // Both thresholds at 3: a step from 3 to 2 crosses each downward
  task automatic t_pulses();
    int n1;
    int n2;
    n1 = 0;
    n2 = 0;
    setup(cfg(mudc_pkg::FN_UPDOWN, mudc_pkg::UD_SPLIT, mudc_pkg::OM_PHIGH,
      mudc_pkg::OM_PLOW), 16'h0003, 16'h0003, 16'h0003);
    src.pulse(2, 1);
    fork
      src.pulse(1, 1);
      repeat (24) begin
        @(negedge hclk);
        n1 += (out1 === 1'b1);
        n2 += (out2 === 1'b1);
      end
    join
    chk("pulse1", PCYC, n1);
    chk("pulse2", PCYC, n2);
  endtask
  task automatic t_down();
    setup(cfg(mudc_pkg::FN_DOWN, mudc_pkg::UD_SPLIT, mudc_pkg::OM_RUN,
      mudc_pkg::OM_NONE), 16'h0000, 16'h0002, 16'h0000);
    src.pulse(1, 1);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'h2);
    outs(1'b1, 1'b0);
    rchk("stat", mudc_pkg::ADDR_STAT, 32'h3);
    src.pulse(0, 3);
    rchk("count", mudc_pkg::ADDR_COUNT, 32'h0);
    outs(1'b0, 1'b0);
  endtask
  // Whole run needs a few hundred cycles; a hang is cut at 20000
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_modulo();
    t_updown();
    t_dir_enc();
    t_pulses();
    t_down();
    summarize();
  end
endmodule // test_modulo_updown_counter_outputs
